// file: pmc_pkg.sv
// Constants and carrier types for the PHY basic control register
package pmc_pkg;

  // ==========================================
  // Register map
  localparam logic [4:0]  PMC_REG_CTL   = 5'h00;
  localparam logic [15:0] PMC_CTL_RESET = 16'h3000;

  // ==========================================
  // Field positions
  localparam int PMC_B_RESET  = 15;
  localparam int PMC_B_LOOP   = 14;
  localparam int PMC_B_SPEED  = 13;
  localparam int PMC_B_AN_EN  = 12;
  localparam int PMC_B_PDOWN  = 11;
  localparam int PMC_B_AN_RST = 9;
  localparam int PMC_B_DUPLEX = 8;
  localparam int PMC_B_COLTST = 7;

  // ==========================================
  // Timing
  localparam int PMC_CLK_MHZ  = 125;
  localparam int PMC_SRST_NS  = 640;
  localparam int PMC_DEAD_NS  = 560;
  localparam int PMC_SRST_CYC = (PMC_SRST_NS * PMC_CLK_MHZ + 999) / 1000;
  localparam int PMC_DEAD_CYC = (PMC_DEAD_NS * PMC_CLK_MHZ + 999) / 1000;

  // ==========================================
  // Carriers
  typedef struct packed {
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } pmc_req_t;

  typedef struct packed {
    logic       dv;
    logic [3:0] data;
  } pmc_nib_t;

endpackage : pmc_pkg

// file: pmc_timer.sv
// One-shot interval timer used for soft reset and loopback dead time
`timescale 1ns/1ns
module pmc_timer #(
  parameter int CYCLES = 8
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic ce,
  // Control
  input  wire logic start,
  output logic      busy,
  output logic      last
);
  import pmc_pkg::*;

  logic [15:0] cnt;

  assign last = busy && (cnt == 16'h0001);

  // ==========================================
  // Down counter, busy for CYCLES cycles
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt  <= 16'h0000;
      busy <= 1'b0;
    end else if (ce) begin
      if (start) begin
        cnt  <= 16'(CYCLES);
        busy <= 1'b1;
      end else if (busy) begin
        cnt  <= cnt - 16'h0001;
        busy <= !last;
      end
    end
  end

endmodule : pmc_timer

// file: pmc_ctl.sv
// PHY basic control register with its loopback, collision and control outputs
// Operation
// - Register reached through the management access port in the CSR space.
// - Writing one to bit 15 returns the registers to defaults; bit self-clears.
// - Reset bit reads one until done; no transaction taken before completion.
// - Bit 14 loops transmit nibbles into the receive path; resets to zero.
// - In loopback, line receive data never reaches the receive path.
// - Entering loopback gives a receive dead interval of about 560 ns.
// - Configured loopback setting overrides the register loopback bit.
// - With auto-negotiation off, bit 13 picks 100 or 10 Mbps; resets one.
// - Speed bit readback is meaningful only with auto-negotiation off.
// - Bit 12 enables auto-negotiation, resets one; speed and duplex ignored.
// - Bit 11 puts the PHY into low power; resets to zero.
// - Writing one to bit 9 restarts auto-negotiation; bit self-clears.
// - With auto-negotiation off, bit 8 picks full or half duplex.
// - With a single supported duplex mode, the duplex bit shows that mode.
// - In loopback, behaviour does not depend on the duplex bit.
// - Bit 7 forces collision whenever transmit enable is high.
`timescale 1ns/1ns
module pmc_ctl #(
  parameter int SRST_CYC = pmc_pkg::PMC_SRST_CYC,
  parameter int DEAD_CYC = pmc_pkg::PMC_DEAD_CYC
) (
  // Clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  // Management access port
  input  wire logic              req_valid,
  input  wire pmc_pkg::pmc_req_t req,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_rdata,
  output logic [15:0]            ctl_word,
  // Configuration and abilities
  input  wire logic              cfg_loop_valid,
  input  wire logic              cfg_loop,
  input  wire logic              able_full,
  input  wire logic              able_half,
  // Nibble data paths
  input  wire pmc_pkg::pmc_nib_t tx,
  input  wire pmc_pkg::pmc_nib_t line_rx,
  input  wire logic              line_crs,
  output pmc_pkg::pmc_nib_t      rx,
  output logic                   col,
  // PHY controls
  output logic                   loop_active,
  output logic                   phy_power_down,
  output logic                   an_enable,
  output logic                   an_restart,
  output logic                   force_100,
  output logic                   force_full
);
  import pmc_pkg::*;

  // ==========================================
  // Request decode
  logic        take;
  logic        hit;
  logic        wr_hit;
  logic        srst_go;
  logic        srst_busy;
  logic        srst_last;
  logic        dead_busy;
  logic        dead_go;
  logic        loop_eff;
  logic        dup_rd;
  logic [15:0] ctl_rd;

  logic loop_bit;
  logic spd_bit;
  logic an_bit;
  logic pd_bit;
  logic an_rst_bit;
  logic dup_bit;
  logic ct_bit;

  assign take   = ce && req_valid && req_ready;
  assign hit    = (req.addr == PMC_REG_CTL);
  assign wr_hit = take && req.wr && hit;
  assign srst_go = wr_hit && req.wdata[PMC_B_RESET];

  // ==========================================
  // Timers
  pmc_timer #(
    .CYCLES (SRST_CYC)
  ) u_srst (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .start   (srst_go),
    .busy    (srst_busy),
    .last    (srst_last)
  );

  assign dead_go = loop_eff && !loop_active;

  pmc_timer #(
    .CYCLES (DEAD_CYC)
  ) u_dead (
    .clk_sys (clk_sys),
    .rst     (rst),
    .ce      (ce),
    .start   (dead_go),
    .busy    (dead_busy),
    .last    ()
  );

  // ==========================================
  // Effective settings
  // configuration loopback wins
  assign loop_eff = cfg_loop_valid ? cfg_loop : loop_bit;

  always_comb begin
    if (able_full && !able_half) begin
      dup_rd = 1'b1;
    end else if (able_half && !able_full) begin
      dup_rd = 1'b0;
    end else begin
      dup_rd = dup_bit;
    end
  end

  // reset bit reads one while busy
  always_comb begin
    ctl_rd               = 16'h0000;
    ctl_rd[PMC_B_RESET]  = srst_busy || srst_go;
    ctl_rd[PMC_B_LOOP]   = loop_bit;
    ctl_rd[PMC_B_SPEED]  = spd_bit;
    ctl_rd[PMC_B_AN_EN]  = an_bit;
    ctl_rd[PMC_B_PDOWN]  = pd_bit;
    ctl_rd[PMC_B_AN_RST] = an_rst_bit;
    ctl_rd[PMC_B_DUPLEX] = dup_rd;
    ctl_rd[PMC_B_COLTST] = ct_bit;
  end

  // ==========================================
  // Control fields
  // reset value 0x3000
  // reserved bits not stored, read zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loop_bit <= PMC_CTL_RESET[PMC_B_LOOP];
      spd_bit  <= PMC_CTL_RESET[PMC_B_SPEED];
      an_bit   <= PMC_CTL_RESET[PMC_B_AN_EN];
      pd_bit   <= PMC_CTL_RESET[PMC_B_PDOWN];
      dup_bit  <= PMC_CTL_RESET[PMC_B_DUPLEX];
      ct_bit   <= PMC_CTL_RESET[PMC_B_COLTST];
    end else if (ce) begin
      if (srst_go) begin
        loop_bit <= PMC_CTL_RESET[PMC_B_LOOP];
        spd_bit  <= PMC_CTL_RESET[PMC_B_SPEED];
        an_bit   <= PMC_CTL_RESET[PMC_B_AN_EN];
        pd_bit   <= PMC_CTL_RESET[PMC_B_PDOWN];
        dup_bit  <= PMC_CTL_RESET[PMC_B_DUPLEX];
        ct_bit   <= PMC_CTL_RESET[PMC_B_COLTST];
      end else if (wr_hit) begin
        loop_bit <= req.wdata[PMC_B_LOOP];
        spd_bit  <= req.wdata[PMC_B_SPEED];
        an_bit   <= req.wdata[PMC_B_AN_EN];
        pd_bit   <= req.wdata[PMC_B_PDOWN];
        dup_bit  <= req.wdata[PMC_B_DUPLEX];
        ct_bit   <= req.wdata[PMC_B_COLTST];
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      an_rst_bit <= 1'b0;
      an_restart <= 1'b0;
    end else if (ce) begin
      an_rst_bit <= wr_hit && !srst_go && req.wdata[PMC_B_AN_RST];
      an_restart <= an_rst_bit;
    end
  end

  // ==========================================
  // Access port answers
  // hold off transactions during reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
      ctl_word  <= PMC_CTL_RESET;
    end else if (ce) begin
      req_ready <= !srst_go && !(srst_busy && !srst_last);
      rsp_valid <= take;
      if (take && !req.wr && hit) begin
        rsp_rdata <= ctl_rd;
      end else if (take) begin
        rsp_rdata <= 16'h0000;
      end
      ctl_word <= ctl_rd;
    end
  end

  // ==========================================
  // PHY control outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loop_active    <= 1'b0;
      phy_power_down <= 1'b0;
      an_enable      <= 1'b1;
      force_100      <= 1'b0;
      force_full     <= 1'b0;
    end else if (ce) begin
      loop_active    <= loop_eff;
      phy_power_down <= pd_bit;
      an_enable      <= an_bit;
      force_100      <= !an_bit && spd_bit;
      force_full     <= !an_bit && (loop_eff || dup_rd);
    end
  end

  // ==========================================
  // Receive path and collision
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx  <= '0;
      col <= 1'b0;
    end else if (ce) begin
      if (pd_bit) begin
        rx <= '0;
      end else if (loop_eff) begin
        rx <= (dead_busy || dead_go) ? '0 : tx;
      end else begin
        rx <= line_rx;
      end
      col <= tx.dv && (ct_bit || (!loop_eff && !force_full && line_crs));
    end
  end

  // ==========================================
  // Assertion helpers
  logic [15:0] ready_low_cnt;
  logic [15:0] loop_age;

  // Cycles spent refusing requests
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ready_low_cnt <= 16'h0000;
    end else if (ce) begin
      if (req_ready) begin
        ready_low_cnt <= 16'h0000;
      end else begin
        ready_low_cnt <= ready_low_cnt + 16'h0001;
      end
    end
  end

  // Cycles since loopback became active
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      loop_age <= 16'h0000;
    end else if (ce) begin
      if (!loop_active) begin
        loop_age <= 16'h0000;
      end else if (loop_age != 16'hffff) begin
        loop_age <= loop_age + 16'h0001;
      end
    end
  end

  // ==========================================
  // Assertions
  AST_SRST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(req_ready) |-> ready_low_cnt == 16'(SRST_CYC))
    else $error("ready not held low after soft reset");

  AST_SRST_END: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(req_ready) |-> ##[1:SRST_CYC] req_ready)
    else $error("soft reset did not complete in time");

  AST_SRST_BIT: assert property (@(posedge clk_sys) disable iff (rst)
    !req_ready |-> ctl_word[15])
    else $error("reset bit not one while busy");

  AST_SRST_DEF: assert property (@(posedge clk_sys) disable iff (rst)
    srst_go |-> ##2 (ctl_word[14:9] == 6'h18) && !an_restart)
    else $error("soft reset left fields set");

  AST_RST_VAL: assert property (@(posedge clk_sys)
    $fell(rst) |-> ctl_word == 16'h3000)
    else $error("reset value wrong");

  AST_LOOP_RX: assert property (@(posedge clk_sys) disable iff (rst)
    $past(loop_eff && !dead_busy && !dead_go && !pd_bit) |-> rx == $past(tx))
    else $error("loopback data mismatch");

  AST_DEAD: assert property (@(posedge clk_sys) disable iff (rst)
    loop_active && (loop_age <= 16'(DEAD_CYC)) |-> !rx.dv)
    else $error("no dead time on loopback entry");

  AST_PRIO: assert property (@(posedge clk_sys) disable iff (rst)
    $past(cfg_loop_valid) |-> loop_active == $past(cfg_loop))
    else $error("configured loopback not honoured");

  AST_AN_IGN: assert property (@(posedge clk_sys) disable iff (rst)
    an_enable |-> !force_100 && !force_full)
    else $error("speed or duplex forced under negotiation");

  AST_PDOWN: assert property (@(posedge clk_sys) disable iff (rst)
    phy_power_down |-> !rx.dv)
    else $error("receive active in power-down");

  AST_RESTART: assert property (@(posedge clk_sys) disable iff (rst)
    wr_hit && !srst_go && req.wdata[9] |-> ##2 an_restart ##1 !ctl_word[9])
    else $error("restart pulse or self-clear missing");

  AST_DUP_ONE: assert property (@(posedge clk_sys) disable iff (rst)
    able_full && !able_half |=> ctl_word[8])
    else $error("duplex bit not forced to supported mode");

  AST_LOOP_DUP: assert property (@(posedge clk_sys) disable iff (rst)
    loop_active && !an_enable |-> force_full)
    else $error("loopback depends on duplex bit");

  AST_COLTST: assert property (@(posedge clk_sys) disable iff (rst)
    $past(ct_bit && tx.dv) |-> col)
    else $error("collision not forced");

  COV_SRST: cover property (@(posedge clk_sys) disable iff (rst)
    srst_go ##1 !req_ready ##[1:80] req_ready);

  COV_LOOP: cover property (@(posedge clk_sys) disable iff (rst)
    $rose(loop_active) ##[1:80] rx.dv);

  COV_COL: cover property (@(posedge clk_sys) disable iff (rst)
    col && !loop_active);

  COV_RESTART: cover property (@(posedge clk_sys) disable iff (rst)
    an_restart);

endmodule : pmc_ctl

// file: pmc_host.sv
// Host management model that drives the register access port
`timescale 1ns/1ns
module pmc_host (
  // Clock
  input  wire logic        clk_sys,
  // Register access port
  input  wire logic        req_ready,
  output logic             req_valid,
  output pmc_pkg::pmc_req_t req
);
  import pmc_pkg::*;

  initial begin
    req_valid = 1'b0;
    req       = '0;
  end

  // ==========================================
  // One access, held until taken or until 400 cycles pass without ready
  // register access port
  task automatic access(input logic wr, input logic [4:0] addr, input logic [15:0] wdata, output logic ok);
    logic rdy;
    int   n;
    ok = 1'b0;
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req       <= '{wr: wr, addr: addr, wdata: wdata & 16'hfb80};
    for (n = 0; n < 400 && !ok; n++) begin
      @(negedge clk_sys);
      rdy = req_ready;
      @(posedge clk_sys);
      ok = rdy;
    end
    req_valid <= 1'b0;
    req       <= ~req;
  endtask : access
endmodule : pmc_host

// file: tb_pmc_ctl.sv
// Self-checking bench for the PHY basic control register
`timescale 1ns/1ns
module tb_pmc_ctl;
  import pmc_pkg::*;
  localparam int SR = 4;
  localparam int DC = 4;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        cfg_v = 1'b0;
  logic        cfg_l = 1'b0;
  logic        af = 1'b1;
  logic        ah = 1'b1;
  logic        crs = 1'b0;
  logic        f;
  pmc_nib_t    tx = '0;
  pmc_nib_t    lrx = '0;
  pmc_nib_t    rx, v, prev;
  pmc_req_t    req;
  logic        req_valid, req_ready, rsp_valid, col, loop_active, ok;
  logic        phy_power_down, an_enable, an_restart, force_100, force_full;
  logic [15:0] rsp_rdata, w, n, e, ctl_word;
  logic [15:0] expq[$];
  int          err_count = 0;
  int          total_checks = 0;

  always #4 clk_sys = ~clk_sys;

  pmc_ctl #(.SRST_CYC(SR), .DEAD_CYC(DC)) pmc_ctl_inst (
    .clk_sys(clk_sys), .rst(rst), .ce(1'b1), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ctl_word(ctl_word), .cfg_loop_valid(cfg_v), .cfg_loop(cfg_l),
    .able_full(af), .able_half(ah), .tx(tx), .line_rx(lrx), .line_crs(crs), .rx(rx), .col(col),
    .loop_active(loop_active), .phy_power_down(phy_power_down), .an_enable(an_enable),
    .an_restart(an_restart), .force_100(force_100), .force_full(force_full));
  pmc_host pmc_host_inst (.clk_sys(clk_sys), .req_ready(req_ready), .req_valid(req_valid), .req(req));

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit

  task automatic conclude;
    if (expq.size() != 0) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, expq.size(), 0);
    end
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  // Request with its expected answer noted first
  task automatic acc(input logic wr, input logic [4:0] a, input logic [15:0] d, input logic [15:0] exp);
    expq.push_back(exp);
    pmc_host_inst.access(wr, a, d, ok);
    if (!ok) begin
      err_count++;
      conclude();
    end
  endtask : acc

  // Expected read value of the control word
  function automatic logic [15:0] rdv(input logic [15:0] d);
    logic [15:0] r;
    r = d & 16'h7980;
    if (af ^ ah) r[PMC_B_DUPLEX] = af;
    return r;
  endfunction : rdv

  // ==========================================
  // Answer monitor
  always @(negedge clk_sys) begin
    if (rsp_valid === 1'b1 && expq.size() > 0) begin
      chk_word(rsp_rdata, expq.pop_front());
    end else if (rsp_valid === 1'b1) begin
      total_checks++;
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, rsp_rdata, 16'h0000);
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(26));
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    acc(1'b0, PMC_REG_CTL, 16'h0000, PMC_CTL_RESET);
    acc(1'b1, 5'h03, 16'h0800, 16'h0000);
    acc(1'b0, 5'h03, 16'h0000, 16'h0000);
    acc(1'b0, PMC_REG_CTL, 16'h0000, PMC_CTL_RESET);
    $display("test reset and map done");
    acc(1'b1, PMC_REG_CTL, 16'h31ff, 16'h0000);
    acc(1'b0, PMC_REG_CTL, 16'h0000, 16'h3180);
    @(posedge clk_sys);
    tx <= '{dv: 1'b1, data: 4'ha};
    repeat (2) @(negedge clk_sys);
    chk_bit(col, 1'b1);
    $display("test collision done");
    acc(1'b1, PMC_REG_CTL, 16'h1200, 16'h0000);
    n = '0;
    repeat (6) begin
      @(negedge clk_sys);
      n = n + {15'h0000, an_restart};
    end
    chk_word(n, 16'h0001);
    chk_bit(col, 1'b0);
    acc(1'b0, PMC_REG_CTL, 16'h0000, 16'h1000);
    $display("test restart done");
    acc(1'b1, PMC_REG_CTL, 16'h0800, 16'h0000);
    lrx <= '{dv: 1'b1, data: 4'h5};
    repeat (3) @(negedge clk_sys);
    chk_bit(phy_power_down, 1'b1);
    chk_word({11'h000, rx}, 16'h0000);
    $display("test power down done");
    @(posedge clk_sys);
    cfg_v <= 1'b1;
    cfg_l <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk_bit(loop_active, 1'b1);
    @(posedge clk_sys);
    cfg_v <= 1'b0;
    cfg_l <= 1'b0;
    acc(1'b1, PMC_REG_CTL, 16'h4000, 16'h0000);
    for (int i = 1; i < DC + 14; i++) begin
      @(posedge clk_sys);
      v = '{dv: 1'b1, data: 4'($urandom)};
      tx <= v;
      lrx <= 5'($urandom);
      @(negedge clk_sys);
      if (i <= DC) chk_word({11'h000, rx}, 16'h0000);
      if (i > DC + 2) chk_word({11'h000, rx}, {11'h000, prev});
      prev = v;
    end
    chk_bit(loop_active, 1'b1);
    @(posedge clk_sys);
    cfg_v <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk_bit(loop_active, 1'b0);
    @(posedge clk_sys);
    cfg_v <= 1'b0;
    $display("test loopback done");
    repeat (24) begin
      @(posedge clk_sys);
      w = 16'($urandom) & 16'h7fff;
      {af, ah} <= 2'($urandom % 3 + 1);
      crs <= 1'($urandom);
      acc(1'b1, PMC_REG_CTL, w, 16'h0000);
      e = rdv(w);
      f = !w[PMC_B_AN_EN] && (w[PMC_B_LOOP] || e[PMC_B_DUPLEX]);
      acc(1'b0, PMC_REG_CTL, 16'h0000, e);
      repeat (2) @(negedge clk_sys);
      chk_word(ctl_word, e);
      chk_bit(an_enable, w[PMC_B_AN_EN]);
      chk_bit(force_100, !w[PMC_B_AN_EN] && w[PMC_B_SPEED]);
      chk_bit(force_full, f);
      chk_bit(col, w[PMC_B_COLTST] || (!w[PMC_B_LOOP] && !f && crs));
      chk_bit(loop_active, w[PMC_B_LOOP]);
    end
    $display("test random fields done");
    acc(1'b1, PMC_REG_CTL, 16'h8000, 16'h0000);
    n = '0;
    @(negedge clk_sys);
    chk_bit(ctl_word[PMC_B_RESET], 1'b1);
    while (req_ready === 1'b0 && n < 16'd100) begin
      n++;
      @(negedge clk_sys);
    end
    chk_word(n, 16'(SR));
    acc(1'b0, PMC_REG_CTL, 16'h0000, rdv(PMC_CTL_RESET));
    repeat (4) @(posedge clk_sys);
    $display("test soft reset done");
    conclude();
  end
endmodule : tb_pmc_ctl
